// *** bench/prf_chk_sva.sv ***
`timescale 1ns/1ps
module prf_chk (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire prf_pkg::prf_bus_t bus_in,
    input wire logic [9:0] sense_current_in,
    input wire logic battery_short_in,
    input wire logic overtemp_in,
    input wire logic [31:0] rdata_out,
    input wire logic sensor_supply_output_out,
    input wire logic demod_out
);
    import prf_pkg::*;
    logic async_q;
    logic frm_rd;
    logic en_wr;
    logic dis_wr;
    function automatic logic [2:0] crc_of(input logic [16:0] d);
        crc_of[2] = CRC_SEED[0] ^ (^(d & 17'h0E5CB));
        crc_of[1] = CRC_SEED[2] ^ (^(d & 17'h1CB97));
        crc_of[0] = CRC_SEED[1] ^ CRC_SEED[0] ^ (^(d & 17'h172E5));
    endfunction
    assign frm_rd = bus_in.rd && bus_in.addr == ADDR_FRAME;
    assign en_wr = bus_in.wr && bus_in.addr == ADDR_CTRL && bus_in.wdata[0];
    assign dis_wr = bus_in.wr && bus_in.addr == ADDR_CTRL && !bus_in.wdata[0];
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            async_q <= 1'b0;
        end else if (bus_in.wr && bus_in.addr == ADDR_CFG) begin
            async_q <= bus_in.wdata[0];
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
        else $error("read data outside answer");
    a_frame_crc: assert property (frm_rd |=> rdata_out[31] ||
        rdata_out[2:0] == crc_of({3'h0, rdata_out[16:3]})) else $error("crc mismatch");
    a_async_id: assert property (frm_rd && async_q |=> rdata_out[31] ||
        rdata_out[14:13] == 2'h0) else $error("async id low bits set");
    a_frame_reread: assert property (frm_rd ##2 frm_rd |=> rdata_out[31])
        else $error("second read not flagged");
    a_otemp_off: assert property (overtemp_in |-> ##[1:3] !sensor_supply_output_out)
        else $error("output on during overtemp");
    a_on_cause: assert property ($rose(sensor_supply_output_out) |->
        $past(en_wr) || $past(en_wr, 2) || $past(en_wr, 3)) else $error("output on unasked");
    a_off_disable: assert property (dis_wr |-> ##[1:2] !sensor_supply_output_out)
        else $error("output on after disable");
    a_stb_stays_on: assert property (sensor_supply_output_out && battery_short_in &&
        !overtemp_in && !$past(overtemp_in) && !dis_wr && sense_current_in < ILIM_LEVEL
        |=> sensor_supply_output_out) else $error("battery short cut output");
    a_gsw_width: assert property (bus_in.rd && bus_in.addr == ADDR_GSW
        |=> rdata_out[31:1] == 31'h0) else $error("status word spare bits");
endmodule
bind prf_receiver prf_chk u_chk (.sys_clk_in, .sys_rst_in, .bus_in, .sense_current_in,
    .battery_short_in, .overtemp_in, .rdata_out, .sensor_supply_output_out, .demod_out);

// *** bench/prf_sensor_model.sv ***
`timescale 1ns/1ps
module prf_sensor_model (
    input wire logic sys_clk_in,
    output logic [9:0] current_out
);
    localparam logic [9:0] QUIESCENT = 10'h080;
    localparam logic [9:0] MODULATED = 10'h0E0;
    initial current_out = QUIESCENT;
    // manchester: bit value is the inverse of the level after mid-bit edge
    task automatic send_bit(input logic b, input int cyc);
        current_out <= b ? MODULATED : QUIESCENT;
        repeat (cyc / 2) @(posedge sys_clk_in);
        current_out <= b ? QUIESCENT : MODULATED;
        repeat (cyc - cyc / 2) @(posedge sys_clk_in);
    endtask
    task automatic send_frame(input logic [15:0] bits, input int n, input int cyc);
        @(posedge sys_clk_in);
        send_bit(1'b0, cyc);
        send_bit(1'b0, cyc);
        for (int i = n - 1; i >= 0; i--) begin
            send_bit(bits[i], cyc);
        end
        current_out <= QUIESCENT;
    endtask
    task automatic glitch(input int n);
        @(posedge sys_clk_in);
        current_out <= MODULATED;
        repeat (n) @(posedge sys_clk_in);
        current_out <= QUIESCENT;
    endtask
endmodule

// *** bench/psi5_receiver_fault_monitor_bench.sv ***
`timescale 1ns/1ps
module psi5_receiver_fault_monitor_bench;
    import prf_pkg::*;
    logic sys_clk_in;
    logic sys_rst_in;
    prf_bus_t bus;
    logic [9:0] model_cur;
    logic [9:0] forced_cur;
    logic [9:0] sense;
    logic force_on;
    logic batt;
    logic hot;
    logic [31:0] rdata;
    logic supply_on;
    logic [31:0] rv;
    int err_count = 0;
    int n_compared = 0;
    assign sense = force_on ? forced_cur : model_cur;
    prf_receiver u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
        .sense_current_in(sense), .battery_short_in(batt), .overtemp_in(hot),
        .rdata_out(rdata), .sensor_supply_output_out(supply_on), .demod_out());
    prf_sensor_model u_sensor (.sys_clk_in(sys_clk_in), .current_out(model_cur));
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_in);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask
    task automatic reg_is(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rd(a);
        chk(rv, e, m);
    endtask
    task automatic on_is(input logic b);
        chk({31'h0, supply_on}, {31'h0, b}, 32'h1);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // whole sequence needs about 40000 cycles
    initial begin
        idle(80000);
        err_count++;
        wrap_up();
    end
    initial begin
        bus = '0;
        force_on = 1'b0;
        forced_cur = 10'h0;
        batt = 1'b0;
        hot = 1'b0;
        sys_rst_in = 1'b1;
        idle(3);
        sys_rst_in <= 1'b0;
        reg_is(4'hF, 32'h0, 32'hFFFFFFFF);
        reg_is(ADDR_GSW, 32'h0, 32'hFFFFFFFF);
        wr(ADDR_TIMES, 32'h04040202);
        wr(ADDR_LEVEL, 32'h00000008);
        wr(ADDR_CTRL, 32'h1);
        idle(2000);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CFG, {28'h0, k == 1, 2'h0, k == 2});
            u_sensor.send_frame(16'h0A5B, 13, k == 1 ? 220 : 200);
            idle(600);
            reg_is(ADDR_FRAME, 32'h000012D8, k == 2 ? 32'h80007FF8 : 32'h80001FF8);
            reg_is(ADDR_FRAME, 32'h80000000, 32'h80000000);
        end
        u_sensor.glitch(GLITCH_CYC / 2);
        idle(600);
        reg_is(ADDR_FRAME, 32'h80000000, 32'h80000000);
        reg_is(ADDR_FAULT, 32'h0, 32'h20);
        for (int n = 10; n <= 16; n += 6) begin
            u_sensor.send_frame(16'hA5B5, n, 200);
            idle(600);
            reg_is(ADDR_GSW, 32'h1, 32'h1);
            reg_is(ADDR_FRAME, 32'h80000000, 32'h80000000);
            reg_is(ADDR_FAULT, 32'h20, 32'h20);
            reg_is(ADDR_FAULT, 32'h0, 32'h20);
        end
        u_sensor.send_frame(16'h0A5B, 13, 200);
        idle(600);
        reg_is(ADDR_FRAME, 32'h0, 32'h80000000);
        repeat (4) begin
            batt <= 1'b1;
            idle(30);
            batt <= 1'b0;
            idle(60);
        end
        reg_is(ADDR_FAULT, 32'h0, 32'h2);
        for (int k = 0; k < 2; k++) begin
            batt <= 1'b1;
            idle(300);
            on_is(1'b1);
            batt <= 1'b0;
            if (k == 0) begin
                reg_is(ADDR_FAULT, 32'h2, 32'h2);
            end else begin
                wr(ADDR_CTRL, 32'h0);
                wr(ADDR_CTRL, 32'h1);
            end
            reg_is(ADDR_FAULT, 32'h0, 32'h2);
        end
        for (int k = 0; k < 2; k++) begin
            force_on <= 1'b1;
            forced_cur <= k == 0 ? 10'h000 : 10'h200;
            idle(1500);
            on_is(1'b1);
            force_on <= 1'b0;
            idle(1500);
            reg_is(ADDR_FAULT, 32'h4 << k, 32'h4 << k);
            reg_is(ADDR_FAULT, 32'h0, 32'h4 << k);
        end
        force_on <= 1'b1;
        forced_cur <= 10'h3FF;
        idle(3000);
        on_is(1'b0);
        force_on <= 1'b0;
        reg_is(ADDR_FAULT, 32'h1, 32'h1);
        reg_is(ADDR_FAULT, 32'h1, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        force_on <= 1'b1;
        idle(3000);
        force_on <= 1'b0;
        reg_is(ADDR_FAULT, 32'h0, 32'h1);
        on_is(1'b1);
        hot <= 1'b1;
        idle(5);
        hot <= 1'b0;
        idle(5);
        on_is(1'b0);
        reg_is(ADDR_FAULT, 32'h10, 32'h10);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        idle(3);
        reg_is(ADDR_FAULT, 32'h0, 32'h10);
        on_is(1'b1);
        wrap_up();
    end
endmodule

// *** design/prf_pkg.sv ***
package prf_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int CUR_LIMIT_STEP_NS = 25000;
    localparam int CUR_LIMIT_STEP_CYC = CUR_LIMIT_STEP_NS / 40;
    localparam int BATT_STEP_PS = 1500000;
    localparam int BATT_STEP_CYC = BATT_STEP_PS / 40000;
    localparam int MIN_BIT_NS = 8000;
    localparam int MIN_BIT_CYC = MIN_BIT_NS / 40;
    localparam int GLITCH_CYC = (MIN_BIT_CYC + 3) / 4;
    localparam int MID_BITS = 13;
    localparam logic [2:0] CRC_SEED = 3'h7;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_FRAME = 4'h2;
    localparam logic [3:0] ADDR_FAULT = 4'h3;
    localparam logic [3:0] ADDR_GSW = 4'h4;
    localparam logic [3:0] ADDR_LEVEL = 4'h5;
    localparam logic [3:0] ADDR_TIMES = 4'h6;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [7:0] ILIM_FILT_RESET = 8'h08;
    localparam logic [7:0] STB_FILT_RESET = 8'h08;
    localparam logic [7:0] OPEN_FILT_RESET = 8'h20;
    localparam logic [7:0] LKG_FILT_RESET = 8'h20;
    localparam logic [7:0] BLANK_RESET = 8'h10;
    localparam logic [9:0] LEAK_LEVEL = 10'h1A4;
    localparam logic [9:0] OPEN_LEVEL = 10'h019;
    localparam logic [9:0] ILIM_LEVEL = 10'h3C0;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } prf_bus_t;

    typedef struct packed {
        logic [3:0] logical_channel_id;
        logic [9:0] data;
        logic [2:0] crc;
    } prf_frame_t;
endpackage

// *** design/prf_receiver.sv ***
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// (RQ1) frame register holds a 4- or 2-bit logical channel id per format; code fills a 3-bit id with bit 0 zero, or a 2-bit id
// (RQ2) asynchronous operation forces the two low id bits to zero
// (RQ3) 3-bit crc, polynomial 1+x+x^3, seed all ones
// (RQ4) crc covers frame bits 16:0 with seed bits all one
// (RQ5) crc bits use the given xor equations, combinationally
// (RQ6) id, data and crc move as one struct to the readout
// (RQ7) start bits checked for duty and period; period check can be disabled
// (RQ8) bit windows timed from clock; pulses under quarter min bit ignored
// (RQ9) after two start bits, missing or extra of 13 transitions is an error
// (RQ10) on bit error drop frame and return to minimum bit time
// (RQ11) every decoder error shows in fault status and summary bit; code drops an unfinished start pair without flagging it
// (RQ12) valid frame stores 10 or 8 data bits unmasked, 8 right-justified
// (RQ13) current sample scaled by 100 and 10 bits tracks quiescent and delta
// (RQ14) trip point is quiescent plus delta threshold; above it gives one
// (RQ15) up-down counter every 25 us; filter reached kills output, sets fault
// (RQ16) current-limit fault clears only on disable then enable
// (RQ17) current-limit detection blanked after each switch-on
// (RQ18) battery counter steps 1.5 us, clears after 1.5 us absent; stay on
// (RQ19) battery fault cleared on read or channel disable
// (RQ20) open flag after tracker zero beyond deglitch; clear on read/disable
// (RQ21) leak flag after excess current beyond deglitch; clear on read/disable
// (RQ22) overtemp kills output and latches until disable then enable
// (RQ23) reading a frame twice returns error until new data arrives
// (RQ24) all crc additions are modulo two
module prf_receiver (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire prf_pkg::prf_bus_t bus_in,
    input wire logic [9:0] sense_current_in,
    input wire logic battery_short_in,
    input wire logic overtemp_in,
    output logic [31:0] rdata_out,
    output logic sensor_supply_output_out,
    output logic demod_out
);
    import prf_pkg::*;

    typedef enum logic [2:0] {
        DEC_IDLE, DEC_START_HI, DEC_START_LO, DEC_BITS
    } prf_dec_t;

    typedef struct packed {
        logic enable;
        logic async_mode;
        logic [1:0] sensor_format_select;
        logic start_period_check_off;
        logic [7:0] ilim_filt;
        logic [7:0] stb_filt;
        logic [7:0] open_filt;
        logic [7:0] lkg_filt;
        logic [7:0] blank_len;
        logic supply;
        logic [9:0] quiescent;
        logic [9:0] delta;
        logic [9:0] peak;
        logic demod;
        logic [5:0] glitch_cnt;
        logic filt_level;
        logic [9:0] ilim_cnt;
        logic [9:0] ilim_pre;
        logic [7:0] blank_cnt;
        logic ground_short_fault;
        logic [5:0] stb_pre;
        logic [7:0] stb_cnt;
        logic [5:0] stb_gone;
        logic battery_short_fault;
        logic [7:0] open_cnt;
        logic open_sensor_fault;
        logic [7:0] lkg_cnt;
        logic ground_leak_fault;
        logic channel_overtemp_fault;
        prf_dec_t dec;
        logic [9:0] bit_timer;
        logic [3:0] starts;
        logic [4:0] trans;
        logic [12:0] shift;
        logic decode_error;
        logic frame_new;
        prf_frame_t sensor_frame_data_reg;
        logic [31:0] rdata;
    } prf_state_t;

    prf_state_t r, next_r;
    logic over_trip;
    logic tick_ilim;
    logic tick_stb;
    logic tick_q;
    logic edge_seen;
    logic [16:0] crc_in;
    logic [2:0] crc_calc;
    logic [10:0] trip;
    logic [9:0] data_field;
    logic [3:0] id_field;
    logic summary;
    logic [9:0] ilim_div;
    logic [5:0] stb_div;

    // free running dividers for the 25 us and 1.5 us steps
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ilim_div <= 10'h000;
            stb_div <= 6'h00;
        end else begin
            ilim_div <= (ilim_div == 10'(CUR_LIMIT_STEP_CYC - 1)) ? 10'h000 : ilim_div + 10'h001;
            stb_div <= (stb_div == 6'(BATT_STEP_CYC - 1)) ? 6'h00 : stb_div + 6'h01;
        end
    end
    assign tick_ilim = (ilim_div == 10'h000);
    assign tick_stb = (stb_div == 6'h00);
    // slow rise of the quiescent estimate, one step per four clocks
    assign tick_q = (ilim_div[1:0] == 2'h0);

    assign trip = {1'b0, r.quiescent} + {1'b0, r.delta}; // RQ14
    assign over_trip = {1'b0, sense_current_in} > trip; // RQ14

    always_comb begin
        // 8-bit words right-justified, data taken unmasked
        data_field = (r.sensor_format_select[0]) ? {2'h0, r.shift[7:0]} : r.shift[9:0]; // RQ12
        id_field = (r.sensor_format_select[0]) ? {r.shift[11:10], 2'h0} : {r.shift[12:10], 1'b0};
        if (r.sensor_format_select[1]) begin
            id_field = {2'h0, r.shift[11:10]}; // RQ1
        end
        if (r.async_mode) begin
            id_field[1:0] = 2'h0; // RQ2
        end
        crc_in = {3'h0, id_field, data_field}; // RQ4
        // modulo-two sums of seed and data bits
        crc_calc[2] = CRC_SEED[0] ^ crc_in[0] ^ crc_in[1] ^ crc_in[3] ^ crc_in[6] ^ crc_in[7]
            ^ crc_in[8] ^ crc_in[10] ^ crc_in[13] ^ crc_in[14] ^ crc_in[15]; // RQ5 RQ24
        crc_calc[1] = CRC_SEED[2] ^ crc_in[0] ^ crc_in[1] ^ crc_in[2] ^ crc_in[4] ^ crc_in[7]
            ^ crc_in[8] ^ crc_in[9] ^ crc_in[11] ^ crc_in[14] ^ crc_in[15]
            ^ crc_in[16]; // RQ5 RQ24
        crc_calc[0] = CRC_SEED[1] ^ CRC_SEED[0] ^ crc_in[0] ^ crc_in[2] ^ crc_in[5]
            ^ crc_in[6] ^ crc_in[7] ^ crc_in[9] ^ crc_in[12] ^ crc_in[13] ^ crc_in[14]
            ^ crc_in[16]; // RQ3 RQ5 RQ24
    end

    assign summary = r.decode_error | r.ground_short_fault | r.battery_short_fault
        | r.open_sensor_fault | r.ground_leak_fault | r.channel_overtemp_fault; // RQ11

    always_comb begin
        next_r = r;
        edge_seen = 1'b0;
        // software access
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                ADDR_CTRL: begin
                    next_r.enable = bus_in.wdata[0];
                end
                ADDR_CFG: begin
                    next_r.async_mode = bus_in.wdata[0];
                    next_r.sensor_format_select = bus_in.wdata[2:1];
                    next_r.start_period_check_off = bus_in.wdata[3]; // RQ7
                end
                ADDR_TIMES: begin
                    next_r.ilim_filt = bus_in.wdata[7:0];
                    next_r.stb_filt = bus_in.wdata[15:8];
                    next_r.open_filt = bus_in.wdata[23:16];
                    next_r.lkg_filt = bus_in.wdata[31:24];
                end
                ADDR_LEVEL: begin
                    next_r.blank_len = bus_in.wdata[7:0];
                end
                default: ;
            endcase
        end
        next_r.rdata = 32'h0000_0000;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                ADDR_CTRL: begin
                    next_r.rdata = {31'h0, r.enable};
                end
                ADDR_CFG: next_r.rdata = {28'h0, r.start_period_check_off,
                    r.sensor_format_select, r.async_mode};
                ADDR_FRAME: begin
                    // one path for id, data and crc; stale read flags error
                    next_r.rdata = {r.frame_new ? 1'b0 : 1'b1, 14'h0,
                        r.sensor_frame_data_reg}; // RQ6 RQ23
                    next_r.frame_new = 1'b0; // RQ23
                end
                ADDR_FAULT: begin
                    next_r.rdata = {26'h0, r.decode_error, r.channel_overtemp_fault,
                        r.ground_leak_fault, r.open_sensor_fault, r.battery_short_fault,
                        r.ground_short_fault};
                    next_r.battery_short_fault = 1'b0; // RQ19
                    next_r.open_sensor_fault = 1'b0; // RQ20
                    next_r.ground_leak_fault = 1'b0; // RQ21
                    next_r.decode_error = 1'b0;
                end
                ADDR_GSW: begin
                    next_r.rdata = {31'h0, summary}; // RQ11
                end
                ADDR_LEVEL: begin
                    next_r.rdata = {2'h0, r.delta, 10'h0, r.quiescent};
                end
                ADDR_TIMES: begin
                    next_r.rdata = {r.lkg_filt, r.open_filt, r.stb_filt, r.ilim_filt};
                end
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        // channel disable clears the battery, open and leak flags; re-enable clears latches
        if (!next_r.enable) begin
            next_r.battery_short_fault = 1'b0; // RQ19
            next_r.open_sensor_fault = 1'b0; // RQ20
            next_r.ground_leak_fault = 1'b0; // RQ21
        end
        if (next_r.enable && !r.enable) begin
            next_r.ground_short_fault = 1'b0; // RQ16
            next_r.channel_overtemp_fault = 1'b0; // RQ22
            next_r.ilim_cnt = 10'h000;
            next_r.blank_cnt = r.blank_len; // RQ17
        end

        // level tracking: slow quiescent, delta from peak excursion
        if (sense_current_in < r.quiescent) begin
            next_r.quiescent = r.quiescent - 10'h001; // RQ13
        end else if (tick_q && sense_current_in > r.quiescent) begin
            next_r.quiescent = r.quiescent + 10'h001; // RQ13
        end
        if (sense_current_in > r.peak) begin
            next_r.peak = sense_current_in;
        end else if (tick_stb && r.peak > r.quiescent) begin
            next_r.peak = r.peak - 10'h001;
        end
        next_r.delta = (r.peak > r.quiescent) ? 10'((r.peak - r.quiescent) >> 1) : 10'h004; // RQ13
        if (next_r.delta < 10'h004) begin
            next_r.delta = 10'h004;
        end
        next_r.demod = over_trip; // RQ14

        // glitch filter: a level must hold a quarter of the minimum bit time
        if (r.demod != r.filt_level) begin
            if (r.glitch_cnt == 6'(GLITCH_CYC - 1)) begin
                next_r.filt_level = r.demod; // RQ8
                next_r.glitch_cnt = 6'h00;
                edge_seen = 1'b1;
            end else begin
                next_r.glitch_cnt = r.glitch_cnt + 6'h01;
            end
        end else begin
            next_r.glitch_cnt = 6'h00; // RQ8
        end
        // manchester decoder
        next_r.bit_timer = (r.bit_timer == 10'h3FF) ? r.bit_timer : r.bit_timer + 10'h001;
        unique case (r.dec)
            DEC_IDLE: if (edge_seen && next_r.filt_level) begin
                next_r.dec = DEC_START_HI;
                next_r.bit_timer = 10'h000;
                next_r.starts = 4'h0;
            end
            DEC_START_HI, DEC_START_LO: if (edge_seen) begin
                // duty: each half at least a quarter bit; period: each half at most one minimum bit
                if (r.bit_timer < 10'(MIN_BIT_CYC / 4) || (!r.start_period_check_off
                        && r.bit_timer > 10'(MIN_BIT_CYC))) begin // RQ7
                    next_r.dec = DEC_IDLE;
                    next_r.decode_error = 1'b1; // RQ10 RQ11
                end else begin
                    next_r.bit_timer = 10'h000;
                    next_r.dec = (r.dec == DEC_START_HI) ? DEC_START_LO : DEC_START_HI;
                    next_r.starts = r.starts + 4'h1;
                    if (r.starts == 4'h1) begin
                        next_r.dec = DEC_BITS;
                        next_r.trans = 5'h00;
                    end
                end
            end
            DEC_BITS: begin
                if (edge_seen && r.bit_timer >= 10'(MIN_BIT_CYC / 2 + MIN_BIT_CYC / 4)) begin
                    next_r.bit_timer = 10'h000;
                    next_r.trans = r.trans + 5'h01;
                    next_r.shift = {r.shift[11:0], ~next_r.filt_level};
                    if (r.trans == 5'(MID_BITS)) begin
                        next_r.dec = DEC_IDLE;
                        next_r.decode_error = 1'b1; // RQ9 RQ10
                    end
                end
                if (r.bit_timer == 10'(MIN_BIT_CYC * 2)) begin
                    next_r.dec = DEC_IDLE;
                    if (r.trans == 5'(MID_BITS)) begin
                        next_r.sensor_frame_data_reg = '{logical_channel_id: id_field,
                            data: data_field, crc: crc_calc}; // RQ6 RQ12
                        next_r.frame_new = 1'b1; // RQ23
                    end else begin
                        next_r.decode_error = 1'b1; // RQ9 RQ10 RQ11
                    end
                end
            end
            default: next_r.dec = DEC_IDLE;
        endcase
        // an unfinished start pair gives up instead of waiting forever
        if ((r.dec == DEC_START_HI || r.dec == DEC_START_LO) && !edge_seen
                && r.bit_timer == 10'(MIN_BIT_CYC * 2)) begin
            next_r.dec = DEC_IDLE; // RQ10
        end

        // current limit filter
        if (r.blank_cnt != 8'h00) begin
            if (tick_ilim) begin
                next_r.blank_cnt = r.blank_cnt - 8'h01; // RQ17
            end
        end else if (tick_ilim && r.supply) begin
            if (sense_current_in >= ILIM_LEVEL) begin
                next_r.ilim_cnt = r.ilim_cnt + 10'h001; // RQ15
            end else if (r.ilim_cnt != 10'h000) begin
                next_r.ilim_cnt = r.ilim_cnt - 10'h001; // RQ15
            end
            if (next_r.ilim_cnt >= {2'h0, r.ilim_filt}) begin
                next_r.ground_short_fault = 1'b1; // RQ15
            end
        end
        // battery short filter
        if (battery_short_in) begin
            next_r.stb_gone = 6'h00;
            if (tick_stb) begin
                next_r.stb_cnt = (r.stb_cnt == 8'hFF) ? r.stb_cnt : r.stb_cnt + 8'h01; // RQ18
            end
            if (r.stb_cnt >= r.stb_filt && r.enable) begin
                next_r.battery_short_fault = 1'b1; // RQ18
            end
        end else if (r.stb_gone == 6'(BATT_STEP_CYC - 1)) begin
            next_r.stb_cnt = 8'h00; // RQ18
        end else begin
            next_r.stb_gone = r.stb_gone + 6'h01;
        end
        // open and leak deglitch
        if (r.quiescent == 10'h000 || sense_current_in < OPEN_LEVEL) begin
            if (tick_stb && r.open_cnt != 8'hFF) begin
                next_r.open_cnt = r.open_cnt + 8'h01;
            end
            if (r.open_cnt > r.open_filt && r.enable) begin
                next_r.open_sensor_fault = 1'b1; // RQ20
            end
        end else begin
            next_r.open_cnt = 8'h00;
        end
        if (sense_current_in > LEAK_LEVEL) begin
            if (tick_stb && r.lkg_cnt != 8'hFF) begin
                next_r.lkg_cnt = r.lkg_cnt + 8'h01;
            end
            if (r.lkg_cnt > r.lkg_filt && r.enable) begin
                next_r.ground_leak_fault = 1'b1; // RQ21
            end
        end else begin
            next_r.lkg_cnt = 8'h00;
        end
        if (overtemp_in && r.enable) begin
            next_r.channel_overtemp_fault = 1'b1; // RQ22
        end
        next_r.supply = next_r.enable && !next_r.ground_short_fault
            && !next_r.channel_overtemp_fault; // RQ15 RQ22
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.ilim_filt <= ILIM_FILT_RESET;
            r.stb_filt <= STB_FILT_RESET;
            r.open_filt <= OPEN_FILT_RESET;
            r.lkg_filt <= LKG_FILT_RESET;
            r.blank_len <= BLANK_RESET;
            r.delta <= 10'h004;
            r.dec <= DEC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_out = r.rdata;
    assign sensor_supply_output_out = r.supply;
    assign demod_out = r.filt_level;
endmodule
